// ==== hdl/cfgd_decoder.v ====
// Configuration word store, setting decoder and memory block guard.
// Assumes a byte-wide programming port synchronous to clock, and a
// memory controller that supplies a block number for each access.
`timescale 1ns/100ps
`include "cfgd_defs.vh"

module cfgd_decoder #(
  parameter [1:0] VARIANT    = `CFGD_VAR_LARGE,
  parameter       NUM_BLOCKS = 6,
  // Arbitrary identification values.
  parameter [7:0] ID_HIGH    = 8'h5A,
  parameter [2:0] ID_PART_LO = 3'h2,
  parameter [4:0] ID_REV     = 5'h03
) (
  // Clock and reset
  input  wire        clock,
  input  wire        arst_n,
  // Programmer port
  input  wire        progWrite,
  input  wire        progRead,
  input  wire [3:0]  progIndex,
  input  wire [7:0]  progWdata,
  output reg  [7:0]  progRdata,
  output reg         progRefused,
  // Reset request, stack fault and watchdog switch from the core
  input  wire        coreReset,
  input  wire        stackFault,
  input  wire        soft_watchdog_switch,
  // Decoded settings
  output reg         watchdogRun,
  output reg         reset_pin_select,
  output reg         port_e_pin_three_en,
  output reg         secondary_osc_low_power,
  output reg  [4:0]  port_b_analog_default,
  output reg         capture2_on_c1,
  output reg         capture2_on_b3,
  output reg         debugPinsGpio,
  output reg         extended_instr_enable,
  output reg  [2:0]  boot_area_size,
  output reg         prog_mode_entry_input,
  output reg         stackResetReq,
  // Memory access check
  input  wire        memRead,
  input  wire        memWrite,
  input  wire [2:0]  accBlock,
  input  wire [2:0]  execBlock,
  input  wire        accBoot,
  input  wire        execBoot,
  input  wire        accData,
  input  wire [7:0]  memRdataIn,
  output reg  [7:0]  memRdataOut,
  output reg         memWriteEn
);

  //////////////////////////////////////////////////////////////////////////
  // Configuration byte store.
  reg  [7:0] wdtWord;
  reg  [7:0] pinWord;
  reg  [7:0] coreWord;
  reg  [7:0] cpLow;
  reg  [7:0] cpHigh;
  reg  [7:0] wrLow;
  reg  [7:0] wrHigh;
  reg  [7:0] rdLow;
  reg  [7:0] rdHigh;

  wire bootGuarded;
  wire cfgLocked;
  wire wrAllowed;

  // Any active guard on the boot area or block zero freezes the size.
  assign bootGuarded = ~cpHigh[`CFGD_H_BOOT] | ~cpLow[0] |
                       ~wrHigh[`CFGD_H_BOOT] | ~wrLow[0] |
                       ~rdHigh[`CFGD_H_BOOT] | ~rdLow[0];
  assign cfgLocked   = ~wrHigh[`CFGD_H_CFG];
  assign wrAllowed   = progWrite & ~cfgLocked;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wdtWord     <= `CFGD_ERASED;
      pinWord     <= `CFGD_ERASED;
      coreWord    <= `CFGD_ERASED;
      cpLow       <= `CFGD_ERASED;
      cpHigh      <= `CFGD_ERASED;
      wrLow       <= `CFGD_ERASED;
      wrHigh      <= `CFGD_ERASED;
      rdLow       <= `CFGD_ERASED;
      rdHigh      <= `CFGD_ERASED;
      progRefused <= 1'b0;
    end else begin
      progRefused <= progWrite & cfgLocked;
      if (wrAllowed) begin
        case (progIndex)
          `CFGD_IDX_WDT:  wdtWord <= progWdata;
          `CFGD_IDX_PIN:  pinWord <= progWdata;
          `CFGD_IDX_CORE: begin
            if (bootGuarded) begin
              coreWord <= (progWdata & ~`CFGD_CORE_BBMASK) |
                          (coreWord & `CFGD_CORE_BBMASK);
            end else begin
              coreWord <= progWdata;
            end
          end
          `CFGD_IDX_CPL:  cpLow  <= progWdata;
          `CFGD_IDX_CPH:  cpHigh <= progWdata;
          `CFGD_IDX_WRL:  wrLow  <= progWdata;
          `CFGD_IDX_WRH:  wrHigh <= progWdata;
          `CFGD_IDX_RDL:  rdLow  <= progWdata;
          `CFGD_IDX_RDH:  rdHigh <= progWdata;
          default: begin
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Programmer readback, including the identification words.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      progRdata <= 8'h00;
    end else if (progRead) begin
      case (progIndex)
        `CFGD_IDX_WDT:  progRdata <= wdtWord;
        `CFGD_IDX_PIN:  progRdata <= pinWord;
        `CFGD_IDX_CORE: progRdata <= coreWord;
        `CFGD_IDX_CPL:  progRdata <= cpLow;
        `CFGD_IDX_CPH:  progRdata <= cpHigh;
        `CFGD_IDX_WRL:  progRdata <= wrLow;
        `CFGD_IDX_WRH:  progRdata <= wrHigh;
        `CFGD_IDX_RDL:  progRdata <= rdLow;
        `CFGD_IDX_RDH:  progRdata <= rdHigh;
        `CFGD_IDX_IDLO: progRdata <= {ID_PART_LO, ID_REV};
        `CFGD_IDX_IDHI: progRdata <= ID_HIGH;
        default:        progRdata <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Boot area size decode per variant.
  reg [2:0] next_bootSize;
  wire [1:0] bbCode;
  assign bbCode = coreWord[`CFGD_CORE_BBHI:`CFGD_CORE_BBLO];

  always @* begin
    next_bootSize = `CFGD_BB_1K;
    case (VARIANT)
      `CFGD_VAR_LARGE: begin
        case (bbCode)
          2'b11, 2'b10: next_bootSize = `CFGD_BB_4K;
          2'b01:        next_bootSize = `CFGD_BB_2K;
          default:      next_bootSize = `CFGD_BB_1K;
        endcase
      end
      `CFGD_VAR_8K: begin
        case (bbCode)
          2'b11, 2'b10: next_bootSize = `CFGD_BB_1K;
          2'b01:        next_bootSize = `CFGD_BB_512;
          default:      next_bootSize = `CFGD_BB_256;
        endcase
      end
      `CFGD_VAR_4K: begin
        if (bbCode == 2'b00) begin
          next_bootSize = `CFGD_BB_256;
        end else begin
          next_bootSize = `CFGD_BB_512;
        end
      end
      default: begin
        if (coreWord[`CFGD_CORE_BBLO]) begin
          next_bootSize = `CFGD_BB_2K;
        end else begin
          next_bootSize = `CFGD_BB_1K;
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Settings are captured while the core is held in reset and then hold.
  reg [NUM_BLOCKS-1:0] codeOk;
  reg [NUM_BLOCKS-1:0] writeOk;
  reg [NUM_BLOCKS-1:0] readOk;
  reg                  bootCodeOk;
  reg                  bootWriteOk;
  reg                  bootReadOk;
  reg                  dataCodeOk;
  reg                  dataWriteOk;
  reg                  wdtFuse;
  reg                  stackRstFuse;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wdtFuse                 <= 1'b1;
      reset_pin_select        <= 1'b1;
      port_e_pin_three_en     <= 1'b0;
      secondary_osc_low_power <= 1'b1;
      port_b_analog_default   <= 5'h1F;
      capture2_on_c1          <= 1'b1;
      capture2_on_b3          <= 1'b0;
      debugPinsGpio           <= 1'b1;
      extended_instr_enable   <= 1'b1;
      boot_area_size          <= `CFGD_BB_1K;
      prog_mode_entry_input   <= 1'b1;
      stackRstFuse            <= 1'b1;
      codeOk                  <= {NUM_BLOCKS{1'b0}};
      writeOk                 <= {NUM_BLOCKS{1'b0}};
      readOk                  <= {NUM_BLOCKS{1'b0}};
      bootCodeOk              <= 1'b0;
      bootWriteOk             <= 1'b0;
      bootReadOk              <= 1'b0;
      dataCodeOk              <= 1'b0;
      dataWriteOk             <= 1'b0;
    end else if (coreReset) begin
      wdtFuse                 <= wdtWord[`CFGD_WDT_ON];
      reset_pin_select        <= pinWord[`CFGD_PIN_RSTE];
      port_e_pin_three_en     <= ~pinWord[`CFGD_PIN_RSTE];
      secondary_osc_low_power <= pinWord[`CFGD_PIN_LPOSC];
      port_b_analog_default   <= {5{pinWord[`CFGD_PIN_PBAD]}};
      capture2_on_c1          <= pinWord[`CFGD_PIN_CCPMX];
      capture2_on_b3          <= ~pinWord[`CFGD_PIN_CCPMX];
      debugPinsGpio           <= coreWord[`CFGD_CORE_DEBUG];
      extended_instr_enable   <= coreWord[`CFGD_CORE_EXTENDED_INSTR_ENABLE];
      boot_area_size          <= next_bootSize;
      prog_mode_entry_input   <= coreWord[`CFGD_CORE_LVP];
      stackRstFuse            <= coreWord[`CFGD_CORE_STKRST];
      codeOk                  <= cpLow[NUM_BLOCKS-1:0];
      writeOk                 <= wrLow[NUM_BLOCKS-1:0];
      readOk                  <= rdLow[NUM_BLOCKS-1:0];
      bootCodeOk              <= cpHigh[`CFGD_H_BOOT];
      dataCodeOk              <= cpHigh[`CFGD_H_DATA];
      bootWriteOk             <= wrHigh[`CFGD_H_BOOT];
      dataWriteOk             <= wrHigh[`CFGD_H_DATA];
      bootReadOk              <= rdHigh[`CFGD_H_BOOT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Watchdog and stack fault reset.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      watchdogRun   <= 1'b0;
      stackResetReq <= 1'b0;
    end else begin
      watchdogRun   <= wdtFuse | soft_watchdog_switch;
      stackResetReq <= stackRstFuse & stackFault;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Access guard for the memory controller.
  reg  readBlocked;
  reg  writeBlocked;
  wire sameArea;
  wire inRange;

  assign sameArea = (accBoot & execBoot) |
                    (~accBoot & ~execBoot & (accBlock == execBlock));
  assign inRange  = ({1'b0, accBlock} < NUM_BLOCKS);

  always @* begin
    readBlocked  = 1'b0;
    writeBlocked = 1'b0;
    if (accData) begin
      readBlocked  = ~dataCodeOk;
      writeBlocked = ~dataWriteOk;
    end else if (accBoot) begin
      readBlocked  = ~bootCodeOk | (~bootReadOk & ~sameArea);
      writeBlocked = ~bootWriteOk;
    end else if (inRange) begin
      readBlocked  = ~codeOk[accBlock] |
                     (~readOk[accBlock] & ~sameArea);
      writeBlocked = ~writeOk[accBlock];
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      memRdataOut <= 8'h00;
      memWriteEn  <= 1'b0;
    end else begin
      memRdataOut <= (memRead & ~readBlocked) ? memRdataIn : 8'h00;
      memWriteEn  <= memWrite & ~writeBlocked;
    end
  end

endmodule

// ==== hdl/cfgd_defs.vh ====
// Constants for the configuration word decoder and block guard.
// Assumes configuration words arrive as bytes from nonvolatile storage.
`ifndef CFGD_DEFS_VH
`define CFGD_DEFS_VH

// Configuration word indices on the programming port.
`define CFGD_IDX_WDT      4'h0
`define CFGD_IDX_PIN      4'h1
`define CFGD_IDX_CORE     4'h2
`define CFGD_IDX_CPL      4'h3
`define CFGD_IDX_CPH      4'h4
`define CFGD_IDX_WRL      4'h5
`define CFGD_IDX_WRH      4'h6
`define CFGD_IDX_RDL      4'h7
`define CFGD_IDX_RDH      4'h8
`define CFGD_IDX_IDLO     4'h9
`define CFGD_IDX_IDHI     4'hA

// Field positions.
`define CFGD_WDT_ON       0
`define CFGD_PIN_LPOSC    2
`define CFGD_PIN_PBAD     1
`define CFGD_PIN_CCPMX    0
`define CFGD_PIN_RSTE     7
`define CFGD_CORE_STKRST  0
`define CFGD_CORE_LVP     2
`define CFGD_CORE_BBLO    4
`define CFGD_CORE_BBHI    5
`define CFGD_CORE_EXTENDED_INSTR_ENABLE   6
`define CFGD_CORE_DEBUG   7
`define CFGD_H_DATA       7
`define CFGD_H_BOOT       6
`define CFGD_H_CFG        5
`define CFGD_CORE_BBMASK  8'h30

// Erased value of every configuration byte.
`define CFGD_ERASED       8'hFF

// Boot area sizes in words, coded as consecutive binary size classes.
`define CFGD_BB_256       3'h0
`define CFGD_BB_512       3'h1
`define CFGD_BB_1K        3'h2
`define CFGD_BB_2K        3'h3
`define CFGD_BB_4K        3'h4

// Variant selectors.
`define CFGD_VAR_LARGE    2'h0
`define CFGD_VAR_8K       2'h1
`define CFGD_VAR_4K       2'h2
`define CFGD_VAR_ONEBIT   2'h3

`endif

// ==== tb/cfgd_decoder_chk.sv ====
// Port checker for the configuration decoder, bound to each instance.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/100ps
module cfgd_decoder_chk (
  // Clock, reset and requests
  input wire       clock, arst_n, progWrite, progRefused, coreReset,
  input wire       stackFault, soft_watchdog_switch, memRead, memWrite,
  // Decoded settings and guard results
  input wire       watchdogRun, reset_pin_select, port_e_pin_three_en,
  input wire       capture2_on_c1, capture2_on_b3, extended_instr_enable,
  input wire       stackResetReq, memWriteEn,
  input wire [4:0] port_b_analog_default,
  input wire [2:0] boot_area_size,
  input wire [7:0] memRdataOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wdog_soft_a:
    assert property (soft_watchdog_switch |=> watchdogRun)
    else $error("watchdog not running");
  pin_excl_a:
    assert property (reset_pin_select != port_e_pin_three_en)
    else $error("reset pin and input pin both or neither");
  analog_all_a:
    assert property (port_b_analog_default == 5'h00 ||
      port_b_analog_default == 5'h1F) else $error("analog pins split");
  route_excl_a:
    assert property (capture2_on_c1 != capture2_on_b3)
    else $error("capture unit routed twice");
  stack_gate_a:
    assert property (!stackFault |=> !stackResetReq)
    else $error("stack reset without fault");
  hold_set_a:
    assert property (!coreReset [*2] |=> $stable({reset_pin_select,
      boot_area_size, extended_instr_enable})) else $error("setting moved");
  read_zero_a:
    assert property (!memRead |=> memRdataOut == 8'h00)
    else $error("read data without read");
  write_gate_a:
    assert property (!memWrite |=> !memWriteEn)
    else $error("write enable without write");
  refuse_why_a:
    assert property (!progWrite |=> !progRefused)
    else $error("refusal without write");
endmodule
bind cfgd_decoder cfgd_decoder_chk i_chk (.*);

// ==== tb/cfgd_prog_model.sv ====
// Programmer model on the configuration programming port.
// Assumes the bench calls wr and rd; signals change on falling edges.
`timescale 1ns/100ps
module cfgd_prog_model (
  // Clock
  input  wire        clock,
  // Programming port
  output logic       progWrite = 1'b0,
  output logic       progRead = 1'b0,
  output logic [3:0] progIndex = 4'h0,
  output logic [7:0] progWdata = 8'h00,
  input  wire  [7:0] progRdata,
  input  wire        progRefused
);
  logic       refused = 1'b0;
  logic [3:0] revision;
  logic       typeBit;
  task automatic wr(input logic [3:0] idx, input logic [7:0] data);
    @(negedge clock);
    progIndex = idx;
    progWdata = data;
    progWrite = 1'b1;
    @(negedge clock);
    progWrite = 1'b0;
    progWdata = ~data;
    refused = progRefused;
  endtask
  task automatic rd(input logic [3:0] idx, output logic [7:0] data);
    @(negedge clock);
    progIndex = idx;
    progRead = 1'b1;
    @(negedge clock);
    progRead = 1'b0;
    data = progRdata;
    // Bit four may name the part rather than the revision.
    if (idx == 4'h9) begin
      revision = data[3:0];
      typeBit = data[4];
    end
  endtask
endmodule

// ==== tb/test_config_fuse_decode_and_block_guard.sv ====
// Self-checking bench for the configuration decoder and block guard.
// Assumes the decoder, its bound checker and the programmer model.
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin \
  nMismatch++; $display("mismatch at %0t: %h not %h", $time, a, b); end end
module test_config_fuse_decode_and_block_guard;
  localparam [7:0] ID_HI = 8'h5A; // Arbitrary identification value.
  localparam [7:0] ID_LO = 8'h43; // Arbitrary part and revision value.
  logic clock = 1'b0, arst_n = 1'b0, coreReset = 1'b0, stackFault = 1'b0;
  logic soft_watchdog_switch = 1'b0, memRead = 1'b0, memWrite = 1'b0;
  logic accBoot = 1'b0, execBoot = 1'b0, accData = 1'b0, pend = 1'b0;
  logic [2:0] accBlock = 3'h0, execBlock = 3'h0, boot_area_size;
  logic [7:0] memRdataIn = 8'h00, progRdata, memRdataOut, progWdata;
  logic [3:0] progIndex;
  logic progWrite, progRead, progRefused, watchdogRun, reset_pin_select;
  logic port_e_pin_three_en, secondary_osc_low_power, capture2_on_c1;
  logic capture2_on_b3, debugPinsGpio, extended_instr_enable, memWriteEn;
  logic prog_mode_entry_input, stackResetReq;
  logic [4:0] port_b_analog_default;
  logic [31:0] rnd = 32'h7499_085c;
  logic [8:0] q[$], exp9;
  int nMismatch = 0, compares = 0;
  // Guard cases as {ok, write, boot, data, block, exec block}.
  logic [9:0] tbl [10] = '{10'h001, 10'h209, 10'h00A, 10'h218, 10'h110,
    10'h318, 10'h040, 10'h180, 10'h340, 10'h281};
  cfgd_decoder #(.ID_HIGH(ID_HI), .ID_PART_LO(ID_LO[7:5]),
    .ID_REV(ID_LO[4:0])) i_dut (.*);
  cfgd_prog_model i_prog (.*);
  // The other boot size variants share every input; only their size is read.
  wire [2:0] bbV [1:3];
  for (genvar v = 1; v < 4; v++) begin : g_var
    cfgd_decoder #(.VARIANT(2'(v)), .ID_HIGH(ID_HI), .ID_PART_LO(ID_LO[7:5]),
      .ID_REV(ID_LO[4:0])) i_dut (.*, .boot_area_size(bbV[v]),
      .progRdata(), .progRefused(), .watchdogRun(), .reset_pin_select(),
      .port_e_pin_three_en(), .secondary_osc_low_power(),
      .port_b_analog_default(), .capture2_on_c1(), .capture2_on_b3(),
      .debugPinsGpio(), .extended_instr_enable(), .prog_mode_entry_input(),
      .stackResetReq(), .memRdataOut(), .memWriteEn());
  end
  always #10 clock = ~clock;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clock) pend <= memRead | memWrite;
  always @(negedge clock) begin
    if (pend) begin
      exp9 = q.pop_front();
      `CHK({memWriteEn, memRdataOut}, exp9)
    end
  end
  task automatic load;
    @(negedge clock);
    coreReset = 1'b1;
    @(negedge clock);
    coreReset = 1'b0;
    repeat (3) @(negedge clock);
  endtask
  task automatic acc(input logic [9:0] c);
    @(negedge clock);
    rnd = lfsr(rnd);
    {memWrite, accBoot, accData, accBlock, execBlock} = c[8:0];
    memRead = ~c[8];
    memRdataIn = rnd[7:0];
    q.push_back({c[9] & c[8], (c[9] & ~c[8]) ? rnd[7:0] : 8'h00});
  endtask
  task automatic results;
    $display("comparisons %0d, mismatches %0d", compares, nMismatch);
    if (nMismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] pin, core, rb;
    logic [2:0] bb;
    repeat (4) @(negedge clock);
    arst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      repeat (24) rnd = lfsr(rnd);
      pin = rnd[7:0];
      core = {rnd[15:14], i[1:0], rnd[11:8]};
      bb = core[5] ? 3'h4 : (core[4] ? 3'h3 : 3'h2);
      i_prog.wr(4'h0, rnd[23:16]);
      i_prog.wr(4'h1, pin);
      i_prog.wr(4'h2, core);
      soft_watchdog_switch = rnd[25];
      stackFault = rnd[24];
      load();
      `CHK(watchdogRun, rnd[16] | rnd[25])
      `CHK({reset_pin_select, port_e_pin_three_en}, {pin[7], ~pin[7]})
      `CHK(secondary_osc_low_power, pin[2])
      `CHK(port_b_analog_default, {5{pin[1]}})
      `CHK({capture2_on_c1, capture2_on_b3}, {pin[0], ~pin[0]})
      `CHK(debugPinsGpio, core[7])
      `CHK(extended_instr_enable, core[6])
      `CHK(boot_area_size, bb)
      `CHK(bbV[1], core[5] ? 3'h2 : {2'h0, core[4]})
      `CHK(bbV[2], {2'h0, |core[5:4]})
      `CHK(bbV[3], {2'h1, core[4]})
      `CHK(prog_mode_entry_input, core[2])
      `CHK(stackResetReq, core[0] & rnd[24])
    end
    stackFault = 1'b0;
    core = ~core;
    i_prog.wr(4'h2, core);
    repeat (3) @(negedge clock);
    `CHK(extended_instr_enable, ~core[6])
    load();
    `CHK(extended_instr_enable, core[6])
    $display("decode test done");
    i_prog.wr(4'h3, 8'hFE);
    i_prog.wr(4'h4, 8'h7F);
    i_prog.wr(4'h5, 8'hFB);
    i_prog.wr(4'h6, 8'hBF);
    i_prog.wr(4'h7, 8'hFD);
    load();
    for (int i = 0; i < 10; i++) acc(tbl[i]);
    @(negedge clock);
    memRead = 1'b0;
    memWrite = 1'b0;
    memRdataIn = ~memRdataIn;
    repeat (2) @(negedge clock);
    $display("guard test done");
    i_prog.wr(4'h2, core ^ 8'h31);
    i_prog.rd(4'h2, rb);
    `CHK(rb, core ^ 8'h01)
    i_prog.wr(4'h6, 8'h9F);
    i_prog.wr(4'h2, 8'h00);
    `CHK(i_prog.refused, 1'b1)
    i_prog.rd(4'h2, rb);
    `CHK(rb, core ^ 8'h01)
    $display("lock test done");
    i_prog.rd(4'h9, rb);
    `CHK(rb, ID_LO)
    `CHK(i_prog.typeBit, ID_LO[4])
    i_prog.rd(4'hA, rb);
    `CHK(rb, ID_HI)
    i_prog.rd(4'hF, rb);
    `CHK(rb, 8'h00)
    $display("ident test done");
    results();
  end
  initial begin
    // Far beyond the roughly 150 cycles that the tests take.
    #200000;
    $display("mismatch at %0t: timeout", $time);
    nMismatch++;
    results();
  end
endmodule
